// *** design/rmrc_pkg.sv ***
// package: constants, state codes and carrier structs of the radio mode and ready control
package rmrc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SWITCH_TIME_NS = 500;
  localparam int unsigned SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] SWITCH_CNT = CNT_W'(SWITCH_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam int unsigned CFG_W = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_READY_BIT = 5;
  localparam int unsigned STAT_LEVEL_LSB = 6;
  localparam int unsigned STAT_TRSEL_BIT = 11;

  // ----------------------------------------
  // data buffer
  // ----------------------------------------
  localparam int unsigned FIFO_W = 1;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned LEVEL_W = 5;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_STBY = 5'b00010,
    ST_SWITCH = 5'b00100,
    ST_TX = 5'b01000,
    ST_RX = 5'b10000
  } rmrc_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rmrc_bus_req_type;

  typedef struct packed {
    logic tr_sel;
    logic standby;
    logic power_down_n;
    logic tx_data;
    logic demod;
  } rmrc_pins_type;

  localparam int unsigned PINS_W = $bits(rmrc_pins_type);

  typedef struct packed {
    logic [2:0] chan;
    logic [1:0] band;
  } rmrc_config_type;

endpackage

// *** design/rmrc_sync.sv ***
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module rmrc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import rmrc_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rmrc_sync_st_type;

  rmrc_sync_st_type st_q;
  rmrc_sync_st_type st_d;

  // first stage feeds only the second
  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule // rmrc_sync

// *** design/rmrc_fifo.sv ***
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module rmrc_fifo #(
  parameter int unsigned W = 1,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic flush_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out,
  // status
  output logic full_out,
  output logic [$clog2(DEPTH):0] level_out
);
  import rmrc_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW:0] wptr;
    logic [PW:0] rptr;
  } rmrc_fifo_st_type;

  rmrc_fifo_st_type st_q;
  rmrc_fifo_st_type st_d;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty
  assign empty = (st_q.wptr == st_q.rptr);
  assign full = (st_q.wptr[PW] != st_q.rptr[PW]) && (st_q.wptr[PW-1:0] == st_q.rptr[PW-1:0]);

  always_comb begin
    st_d = st_q;
    if (flush_in) begin
      st_d.wptr = '0;
      st_d.rptr = '0;
    end else begin
      if (in_valid_in && !full) begin
        st_d.mem[st_q.wptr[PW-1:0]] = in_data_in;
        st_d.wptr = st_q.wptr + 1'b1;
      end
      if (out_ready_in && !empty) begin
        st_d.rptr = st_q.rptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = st_q.mem[st_q.rptr[PW-1:0]];
  assign full_out = full;
  assign level_out = st_q.wptr - st_q.rptr;

endmodule // rmrc_fifo

// *** design/rmrc_top.sv ***
// radio mode and ready control: pin-level mode resolution, transparent data paths, ready line
//
// Functional notes
// - data passes through with no framing
// - select high means transmit the input
// - select low means drive demodulated data out
// - receive output is never squelched
// - ready high during every transmit/receive switch
// - switching keeps band and channel settings
// - ready high busy, low ready; flow control
// - standby high deactivates all modes
// - ready held high in standby
// - power-down performs no function
// - ready reads low in power-down
// - power-down input is active low
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module rmrc_top (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // register port
  input wire logic [rmrc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [rmrc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [rmrc_pkg::DATA_W-1:0] rdata_out,
  // control pins from the host
  input wire logic tr_sel_in,
  input wire logic standby_in,
  input wire logic power_down_n_in,
  // data pins
  input wire logic tx_data_in,
  output logic rx_data_out,
  output logic ready_out,
  // radio core side
  input wire logic demod_in,
  input wire logic mod_ready_in,
  output logic mod_data_out,
  output logic mod_valid_out,
  output logic tx_en_out,
  output logic rx_en_out,
  output logic [1:0] band_out,
  output logic [2:0] channel_out
);
  import rmrc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rmrc_state_type state;
    logic [CNT_W-1:0] cnt;
    rmrc_config_type cfg;
    logic tr_prev;
    logic ready;
    logic rx_data;
    logic mod_data;
    logic mod_valid;
    logic tx_en;
    logic rx_en;
    logic [DATA_W-1:0] rdata;
  } rmrc_top_st_type;

  rmrc_top_st_type st_q;
  rmrc_top_st_type st_d;
  rmrc_bus_req_type bus;
  rmrc_pins_type pins_raw;
  rmrc_pins_type pins;
  logic [PINS_W-1:0] pins_vec;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_out_data;
  logic fifo_full;
  logic fifo_flush;
  logic [LEVEL_W-1:0] fifo_level;
  logic active;
  logic tr_change;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign pins_raw = '{tr_sel: tr_sel_in, standby: standby_in, power_down_n: power_down_n_in,
                      tx_data: tx_data_in, demod: demod_in};

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  rmrc_sync #(
    .W(PINS_W)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in(pins_raw),
    .sync_out(pins_vec)
  );

  assign pins = rmrc_pins_type'(pins_vec);

  // ----------------------------------------
  // transmit buffer
  // ----------------------------------------
  // bits are sampled every cycle, so a stalled modulator fills it and raises ready
  assign fifo_flush = (st_q.state != ST_TX);
  assign fifo_in_valid = (st_q.state == ST_TX);
  assign fifo_out_ready = (st_q.state == ST_TX) && mod_ready_in;

  rmrc_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .flush_in(fifo_flush),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(pins.tx_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data),
    .full_out(fifo_full),
    .level_out(fifo_level)
  );

  // ----------------------------------------
  // mode resolution and data paths
  // ----------------------------------------
  assign active = (st_q.state == ST_SWITCH) || (st_q.state == ST_TX) || (st_q.state == ST_RX);
  assign tr_change = active && (pins.tr_sel != st_q.tr_prev);

  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    if (!pins.power_down_n) begin
      st_d.state = ST_OFF;
    end else if (pins.standby) begin
      st_d.state = ST_STBY;
    end else if (!active || tr_change) begin
      // wake-up and every direction change take the same settling time
      st_d.state = ST_SWITCH;
      st_d.cnt = SWITCH_CNT;
    end else if (st_q.state == ST_SWITCH) begin
      if (st_q.cnt == CNT_ONE) begin
        st_d.state = pins.tr_sel ? ST_TX : ST_RX;
        st_d.cnt = CNT_ZERO;
      end else begin
        st_d.cnt = st_q.cnt - CNT_ONE;
      end
    end
    st_d.tr_prev = pins.tr_sel;
    st_d.tx_en = (st_d.state == ST_TX);
    st_d.rx_en = (st_d.state == ST_RX);
    // no squelch: whatever the demodulator gives is passed on
    st_d.rx_data = (st_d.state == ST_RX) ? pins.demod : 1'b0;
    // no bit reaches the modulator once the mode has left transmit
    st_d.mod_valid = (st_d.state == ST_TX) && fifo_out_ready && fifo_out_valid;
    // an empty buffer shows a stale entry, so only a real pop moves the bit
    st_d.mod_data = (fifo_out_ready && fifo_out_valid) ? fifo_out_data : st_q.mod_data;
    unique case (st_d.state)
      ST_OFF: st_d.ready = 1'b0;
      ST_STBY: st_d.ready = 1'b1;
      ST_SWITCH: st_d.ready = 1'b1;
      ST_TX: st_d.ready = !fifo_in_ready;
      ST_RX: st_d.ready = 1'b0;
    endcase
    // register port: config writes ignored while powered down
    if (bus.wr && (bus.addr == REG_CONFIG) && (st_q.state != ST_OFF)) begin
      st_d.cfg = rmrc_config_type'(bus.wdata[CFG_W-1:0]);
    end
    if (bus.rd) begin
      unique case (bus.addr)
        REG_CONFIG: st_d.rdata[CFG_W-1:0] = st_q.cfg;
        REG_STATUS: begin
          st_d.rdata[STAT_STATE_LSB +: $bits(rmrc_state_type)] = st_q.state;
          st_d.rdata[STAT_READY_BIT] = st_q.ready;
          st_d.rdata[STAT_LEVEL_LSB +: LEVEL_W] = fifo_level;
          st_d.rdata[STAT_TRSEL_BIT] = st_q.tr_prev;
        end
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '{state: ST_OFF, cnt: CNT_ZERO, cfg: CFG_RESET, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata_out = st_q.rdata;
  assign rx_data_out = st_q.rx_data;
  assign ready_out = st_q.ready;
  assign mod_data_out = st_q.mod_data;
  assign mod_valid_out = st_q.mod_valid;
  assign tx_en_out = st_q.tx_en;
  assign rx_en_out = st_q.rx_en;
  assign band_out = st_q.cfg.band;
  assign channel_out = st_q.cfg.chan;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_off_ready_low;
    @(posedge clk_sys_in) disable iff (reset_in)
    (st_q.state == ST_OFF) |-> !ready_out;
  endproperty
  a_off_ready_low: assert property (p_off_ready_low) else $error("ready high in power-down");

  property p_stby_ready_high;
    @(posedge clk_sys_in) disable iff (reset_in)
    (st_q.state == ST_STBY) |-> (ready_out && !tx_en_out && !rx_en_out);
  endproperty
  a_stby_ready_high: assert property (p_stby_ready_high) else $error("standby not busy or mode on");

  property p_switch_busy;
    @(posedge clk_sys_in) disable iff (reset_in)
    (tr_change && pins.power_down_n && !pins.standby) |=> (st_q.state == ST_SWITCH) && ready_out && (st_q.cnt == SWITCH_CNT);
  endproperty
  a_switch_busy: assert property (p_switch_busy) else $error("no busy period after select change");

  property p_switch_ends;
    @(posedge clk_sys_in) disable iff (reset_in)
    (st_q.state == ST_SWITCH && st_q.cnt == CNT_ONE && !tr_change && pins.power_down_n && !pins.standby)
      |=> (st_q.state == ($past(pins.tr_sel) ? ST_TX : ST_RX)) && !ready_out
          && (tx_en_out == $past(pins.tr_sel)) && (rx_en_out != tx_en_out);
  endproperty
  a_switch_ends: assert property (p_switch_ends) else $error("switch did not end in selected mode");

  property p_rx_passthrough;
    @(posedge clk_sys_in) disable iff (reset_in)
    (st_q.state == ST_RX) |-> (rx_data_out == $past(pins.demod)) && rx_en_out;
  endproperty
  a_rx_passthrough: assert property (p_rx_passthrough) else $error("receive data not passed through");

  property p_off_silent;
    @(posedge clk_sys_in) disable iff (reset_in)
    (st_q.state == ST_OFF) |-> !tx_en_out && !rx_en_out && !rx_data_out && !mod_valid_out;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("activity in power-down");

  property p_cfg_kept;
    @(posedge clk_sys_in) disable iff (reset_in)
    !wr_in |=> $stable(st_q.cfg);
  endproperty
  a_cfg_kept: assert property (p_cfg_kept) else $error("settings changed without a write");

  property p_tx_flow;
    @(posedge clk_sys_in) disable iff (reset_in)
    (st_q.state == ST_TX && $past(st_q.state == ST_TX)) |-> (ready_out == $past(fifo_full));
  endproperty
  a_tx_flow: assert property (p_tx_flow) else $error("ready does not follow buffer full");

  property p_mod_data;
    @(posedge clk_sys_in) disable iff (reset_in)
    mod_valid_out |-> $past(fifo_out_valid) && (mod_data_out == $past(fifo_out_data));
  endproperty
  a_mod_data: assert property (p_mod_data) else $error("modulator bit differs from buffer");

  property p_priority;
    @(posedge clk_sys_in) disable iff (reset_in)
    (!pins.power_down_n |=> st_q.state == ST_OFF) and (pins.power_down_n && pins.standby |=> st_q.state == ST_STBY);
  endproperty
  a_priority: assert property (p_priority) else $error("control inputs resolved in wrong order");

  property p_pd_outputs;
    @(posedge clk_sys_in) disable iff (reset_in)
    !pins.power_down_n |=> !ready_out && !tx_en_out && !rx_en_out && !mod_valid_out;
  endproperty
  a_pd_outputs: assert property (p_pd_outputs) else $error("power-down left an output active");

  property p_stby_busy;
    @(posedge clk_sys_in) disable iff (reset_in)
    (pins.power_down_n && pins.standby) |=> ready_out && !tx_en_out && !rx_en_out;
  endproperty
  a_stby_busy: assert property (p_stby_busy) else $error("standby input did not make the block busy");

  property p_cfg_write;
    @(posedge clk_sys_in) disable iff (reset_in)
    (wr_in && (addr_in == REG_CONFIG) && (st_q.state != ST_OFF)) |=> ({channel_out, band_out} == $past(wdata_in[CFG_W-1:0]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("settings write did not land");

  property p_mod_only_tx;
    @(posedge clk_sys_in) disable iff (reset_in)
    mod_valid_out |-> tx_en_out && !rx_en_out;
  endproperty
  a_mod_only_tx: assert property (p_mod_only_tx) else $error("modulator fed outside transmit");

  property p_rx_quiet;
    @(posedge clk_sys_in) disable iff (reset_in)
    !rx_en_out |-> !rx_data_out;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("receive data driven outside receive");

  property p_switch_count;
    @(posedge clk_sys_in) disable iff (reset_in)
    (st_q.state == ST_SWITCH) |-> (st_q.cnt != CNT_ZERO) && (st_q.cnt <= SWITCH_CNT) && ready_out;
  endproperty
  a_switch_count: assert property (p_switch_count) else $error("settling count out of range");

endmodule // rmrc_top

// *** test/rmrc_host_model.sv ***
// host model: drives the mode pins and a slow transmit stream
`timescale 1ns/1ps
module rmrc_host_model #(
  parameter int unsigned BIT_CYCLES = 80
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // requests from the bench
  input wire logic want_tx_in,
  input wire logic want_stby_in,
  input wire logic want_off_in,
  input wire logic stream_in,
  // device pins
  input wire logic ready_in,
  output logic tr_sel_out,
  output logic standby_out,
  output logic power_down_n_out,
  output logic tx_data_out
);
  // ----------------
  // pin driver
  // ----------------
  logic [7:0] cnt_q;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      tr_sel_out <= 1'b0;
      standby_out <= 1'b1;
      power_down_n_out <= 1'b1;
      tx_data_out <= 1'b0;
      cnt_q <= 8'h00;
    end else if (want_off_in) begin
      // inputs low first, else the part may half wake
      tr_sel_out <= 1'b0;
      standby_out <= 1'b0;
      tx_data_out <= 1'b0;
      power_down_n_out <= tr_sel_out | standby_out | tx_data_out;
    end else begin
      power_down_n_out <= 1'b1;
      tr_sel_out <= want_tx_in;
      standby_out <= want_stby_in;
      // 250 kbps at 20 MHz; stream held while busy
      if (stream_in && !ready_in) begin
        cnt_q <= (cnt_q == 8'(BIT_CYCLES - 1)) ? 8'h00 : cnt_q + 8'h01;
        if (cnt_q == 8'(BIT_CYCLES - 1)) tx_data_out <= ~tx_data_out;
      end
    end
  end
endmodule // rmrc_host_model

// *** test/test_rmrc_top.sv ***
// testbench for the radio mode and ready control
`timescale 1ns/1ps
module test_rmrc_top;
  import rmrc_pkg::*;
  // ----------------
  // signals
  // ----------------
  logic clk_sys_in, reset_in, wr_in, rd_in, tr_sel, standby, pd_n, tx_data_in;
  logic [3:0] addr_in;
  logic [31:0] wdata_in, rdata_out;
  logic rx_data_out, ready_out, demod_in, mod_ready_in, mod_data_out, mod_valid_out, tx_en, rx_en;
  logic [1:0] band_out;
  logic [2:0] channel_out;
  logic want_tx, want_stby, want_off, stream;
  int n_mismatch = 0;
  int n_compared = 0;

  rmrc_top dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tr_sel_in(tr_sel), .standby_in(standby),
    .power_down_n_in(pd_n), .tx_data_in(tx_data_in), .rx_data_out(rx_data_out), .ready_out(ready_out),
    .demod_in(demod_in), .mod_ready_in(mod_ready_in), .mod_data_out(mod_data_out),
    .mod_valid_out(mod_valid_out), .tx_en_out(tx_en), .rx_en_out(rx_en), .band_out(band_out),
    .channel_out(channel_out));
  rmrc_host_model host (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .want_tx_in(want_tx),
    .want_stby_in(want_stby), .want_off_in(want_off), .stream_in(stream), .ready_in(ready_out),
    .tr_sel_out(tr_sel), .standby_out(standby), .power_down_n_out(pd_n), .tx_data_out(tx_data_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // ----------------
  // tasks
  // ----------------
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic chk_status(input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(REG_STATUS, d);
    cmp(d & mask, exp);
  endtask
  task automatic wait_ready(input logic v);
    for (int i = 0; i < 60 && ready_out !== v; i++) cyc(1);
    cmp(32'(ready_out), 32'(v));
  endtask
  // counts busy cycles of one select change; ready must be low before
  task automatic switch_len();
    int n;
    n = 0;
    for (int i = 0; i < 40 && (n == 0 || ready_out === 1'b1); i++) begin
      cyc(1);
      if (ready_out === 1'b1) n++;
    end
    cmp(32'(n), 32'(SWITCH_CYCLES));
  endtask

  // ----------------
  // tests
  // ----------------
  initial begin
    logic [31:0] d;
    logic v;
    reset_in = 1'b1;
    addr_in = 4'h0;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    demod_in = 1'b0;
    mod_ready_in = 1'b1;
    want_tx = 1'b0;
    want_stby = 1'b1;
    want_off = 1'b0;
    stream = 1'b0;
    cyc(16);
    reset_in <= 1'b0;
    wait_ready(1'b1);
    chk_status(32'h3f, 32'h22);
    cmp(32'({tx_en, rx_en}), 32'h0);
    reg_wr(REG_CONFIG, 32'h1d);
    cyc(1);
    cmp(32'({band_out, channel_out}), 32'h0f);
    reg_wr(REG_STATUS, 32'hfff);
    chk_status(32'h3f, 32'h22);
    reg_rd(4'h8, d);
    cmp(d, 32'h0);
    // wake into transmit
    want_tx <= 1'b1;
    want_stby <= 1'b0;
    cyc(2);
    wait_ready(1'b0);
    cmp(32'({tx_en, rx_en}), 32'h2);
    chk_status(32'h83f, 32'h808);
    // transmit to receive
    want_tx <= 1'b0;
    switch_len();
    cmp(32'({tx_en, rx_en}), 32'h1);
    cmp(32'({band_out, channel_out}), 32'h0f);
    chk_status(32'h83f, 32'h010);
    // raw demodulated levels pass unsquelched
    for (int i = 0; i < 8; i++) begin
      demod_in <= 1'(8'hb2 >> i);
      cyc(8);
      cmp(32'(rx_data_out), 32'((8'hb2 >> i) & 8'h01));
    end
    cmp(32'(mod_valid_out), 32'h0);
    // receive to transmit, then stream
    want_tx <= 1'b1;
    switch_len();
    cmp(32'({band_out, channel_out}), 32'h0f);
    stream <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      v = tx_data_in;
      for (int i = 0; i < 200 && tx_data_in === v; i++) cyc(1);
      cyc(40);
      cmp(32'(mod_data_out), 32'(tx_data_in));
      cmp(32'(mod_valid_out), 32'h1);
      cmp(32'(ready_out), 32'h0);
    end
    // stalled modulator fills the buffer, ready flags busy
    mod_ready_in <= 1'b0;
    wait_ready(1'b1);
    chk_status(32'h7c0, 32'(FIFO_DEPTH) << 6);
    mod_ready_in <= 1'b1;
    wait_ready(1'b0);
    // standby from transmit
    want_stby <= 1'b1;
    wait_ready(1'b1);
    cyc(5);
    cmp(32'({tx_en, rx_en, mod_valid_out}), 32'h0);
    chk_status(32'h3f, 32'h22);
    // power-down
    want_off <= 1'b1;
    wait_ready(1'b0);
    chk_status(32'h3f, 32'h01);
    for (int i = 0; i < 4; i++) begin
      demod_in <= ~demod_in;
      cyc(4);
      cmp(32'({rx_data_out, mod_valid_out, tx_en, rx_en}), 32'h0);
    end
    reg_wr(REG_CONFIG, 32'h02);
    cyc(1);
    cmp(32'({band_out, channel_out}), 32'h0f);
    // wake into receive
    want_off <= 1'b0;
    want_stby <= 1'b0;
    want_tx <= 1'b0;
    wait_ready(1'b1);
    wait_ready(1'b0);
    cmp(32'({tx_en, rx_en}), 32'h1);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_mismatch++;
    stop_test();
  end
endmodule // test_rmrc_top
